// ==== verilog/ccr_regs.svh ====
// register offsets, reset values, field positions and timing counts
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// register byte offsets on the serial bus
`define CCR_ADDR_CTL_A 8'h15
`define CCR_ADDR_CTL_B 8'h16
`define CCR_ADDR_CTL_C 8'h17

// power-on and software reset values
`define CCR_RST_CTL_A 8'h26
`define CCR_RST_CTL_B 8'hA1

// field positions
`define CCR_KICK_BIT 2
`define CCR_REGRST_BIT 7

// serial target address, value is arbitrary
`define CCR_I2C_ADDR 7'h2A

// watchdog base period in seconds and clock rate in hertz
`define CCR_WD_BASE_S 40
`define CCR_CLK_HZ 40_000_000

`endif

// ==== verilog/ccr_pkg.sv ====
// types shared by the charger control register bank
`default_nettype none
package ccr_pkg;

	// serial target protocol states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_WPTR = 4'h3,
		ST_WPTR_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK = 4'h8
	} ccr_i2c_e;

	// first control register layout, bit 7 first
	typedef struct packed {
		logic input_switch_full_on;
		logic battery_switch_full_on;
		logic trickle_current_sel;
		logic [1:0] topoff_duration;
		logic termination_enable;
		logic input_limit_tracking;
		logic recharge_offset;
	} ccr_ctl_a_s;

	// second control register layout, bit 7 first
	typedef struct packed {
		logic auto_battery_discharge;
		logic forced_battery_pulldown;
		logic charge_enable;
		logic high_impedance_mode;
		logic mid_node_pulldown;
		logic watchdog_kick;
		logic [1:0] watchdog_period;
	} ccr_ctl_b_s;

	// pin synchroniser with a delayed copy for edge detection
	typedef struct packed {
		logic s1;
		logic s2;
		logic d;
	} ccr_sync_s;

	// whole state of the register bank
	typedef struct packed {
		ccr_i2c_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic sda_oe;
		logic ack_ok;
		ccr_ctl_a_s ctl_a;
		ccr_ctl_b_s ctl_b;
		logic soft_rst;
		logic kick;
		logic dsch_on;
		ccr_sync_s scl;
		ccr_sync_s sda;
		ccr_sync_s plug;
		logic [1:0] ovp;
	} ccr_state_s;

	// whole state of the watchdog
	typedef struct packed {
		logic [32:0] cnt;
		logic expired;
	} ccr_wdog_s;

endpackage
`default_nettype wire

// ==== verilog/ccr_wdog.sv ====
// host watchdog timer with selectable period
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"

module ccr_wdog #(
	parameter logic [32:0] BASE_CYCLES = 33'(`CCR_WD_BASE_S * `CCR_CLK_HZ)
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic [1:0] period,
	output logic expired
);
	import ccr_pkg::*;

	ccr_wdog_s state_reg; // registered state
	ccr_wdog_s state_next; // next state
	logic [32:0] limit; // cycles in the chosen period

	// period code 01, 10, 11 doubles the base each step
	always_comb
	begin
		unique case (period)
			2'b01: limit = BASE_CYCLES;
			2'b10: limit = BASE_CYCLES << 1;
			2'b11: limit = BASE_CYCLES << 2;
			default: limit = BASE_CYCLES; // 00 stops the count anyway
		endcase
	end

	// count up, fire a one-cycle pulse on reaching the limit
	always_comb
	begin
		state_next = state_reg;
		state_next.expired = 1'b0;
		if (restart || period == 2'b00)
		begin
			state_next.cnt = '0;
		end
		else if (state_reg.cnt >= 33'(limit - 33'h1))
		begin
			state_next.cnt = '0;
			state_next.expired = 1'b1;
		end
		else
		begin
			state_next.cnt = 33'(state_reg.cnt + 33'h1);
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign expired = state_reg.expired;

endmodule // ccr_wdog
`default_nettype wire

// ==== verilog/ccr_charger_ctrl.sv ====
// charger control register bank behind a two-wire serial target
// Functional notes
// - input switch full on overrides current limit
// - battery switch full on overrides charge current
// - trickle current select, default 80mA
// - two-bit top-off duration, 00 off
// - termination enable, watchdog restores one
// - input limit tracks battery plus offset
// - recharge offset 100mV or 200mV
// - auto discharge during battery overvoltage fault
// - forced battery pull-down, watchdog clears it
// - charge enable, watchdog restores one
// - high impedance cleared on adapter plug-in
// - mid node pull-down, watchdog clears it
// - kick bit restarts watchdog, self-clears
// - watchdog period: off, 40, 80, 160s
// - second register resets to A1 hex
// - register reset bit restores defaults, self-clears
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"

module ccr_charger_ctrl #(
	parameter logic [32:0] WD_BASE_CYCLES = 33'(`CCR_WD_BASE_S * `CCR_CLK_HZ)
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic battery_ovp_fault,
	input wire logic adapter_present,
	output logic input_switch_full_on,
	output logic battery_switch_full_on,
	output logic trickle_current_sel,
	output logic [1:0] topoff_duration,
	output logic termination_enable,
	output logic input_limit_tracking,
	output logic recharge_offset,
	output logic battery_discharge_on,
	output logic forced_battery_pulldown,
	output logic charge_enable,
	output logic high_impedance_mode,
	output logic mid_node_pulldown,
	output logic [1:0] watchdog_period,
	output logic watchdog_expired
);
	import ccr_pkg::*;

	logic [1:0] rst_sync_reg; // reset release synchroniser
	logic rst_n; // synchronised reset used everywhere else
	ccr_state_s state_reg; // registered state
	ccr_state_s state_next; // next state
	logic scl_rise; // serial clock rising edge
	logic scl_fall; // serial clock falling edge
	logic bus_start; // start condition seen
	logic bus_stop; // stop condition seen
	logic plug_rise; // adapter just plugged in
	logic [7:0] rd_byte; // byte at the register pointer
	logic wr_en; // a data byte completed this cycle
	logic wd_fire; // watchdog expiry pulse

	// reset is asserted at once and released two edges later
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	// edges are taken between the second stage and its delayed copy,
	// so the first synchroniser stage never feeds any logic
	assign scl_rise = state_reg.scl.s2 & ~state_reg.scl.d;
	assign scl_fall = ~state_reg.scl.s2 & state_reg.scl.d;
	assign plug_rise = state_reg.plug.s2 & ~state_reg.plug.d;

	// data changes while the clock is high mark start and stop
	assign bus_start = state_reg.scl.s2 & state_reg.scl.d
		& state_reg.sda.d & ~state_reg.sda.s2;
	assign bus_stop = state_reg.scl.s2 & state_reg.scl.d
		& ~state_reg.sda.d & state_reg.sda.s2;

	// read data mux; unmapped offsets and spare bits read zero
	always_comb
	begin
		case (state_reg.ptr)
			`CCR_ADDR_CTL_A: rd_byte = state_reg.ctl_a;
			`CCR_ADDR_CTL_B:
			begin
				rd_byte = state_reg.ctl_b;
				rd_byte[`CCR_KICK_BIT] = 1'b0;
			end
			`CCR_ADDR_CTL_C: rd_byte = {state_reg.soft_rst, 7'h00};
			default: rd_byte = 8'h00;
		endcase
	end

	// watchdog, restarted by a kick or by a register reset
	ccr_wdog #(
		.BASE_CYCLES(WD_BASE_CYCLES)
	) u_wdog (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.restart(state_reg.kick | state_reg.soft_rst),
		.period(state_reg.ctl_b.watchdog_period),
		.expired(wd_fire)
	);

	// next-state logic: pins, serial protocol, then register updates
	always_comb
	begin
		state_next = state_reg;
		wr_en = 1'b0;
		state_next.kick = 1'b0;

		// two-flop synchronisers on every pin input
		state_next.scl = '{s1: scl_in, s2: state_reg.scl.s1, d: state_reg.scl.s2};
		state_next.sda = '{s1: sda_in, s2: state_reg.sda.s1, d: state_reg.sda.s2};
		state_next.plug = '{s1: adapter_present, s2: state_reg.plug.s1,
			d: state_reg.plug.s2};
		state_next.ovp = {state_reg.ovp[0], battery_ovp_fault};

		// discharge only while both enabled and the fault stands
		state_next.dsch_on = state_reg.ctl_b.auto_battery_discharge
			& state_reg.ovp[1];

		// a start aborts anything and begins an address byte
		if (bus_start)
		begin
			state_next.st = ST_ADDR;
			state_next.cnt = 4'h0;
			state_next.sda_oe = 1'b0;
		end
		// a stop always frees the line
		else if (bus_stop)
		begin
			state_next.st = ST_IDLE;
			state_next.sda_oe = 1'b0;
		end
		// rising edge: sample data, or the host acknowledge
		else if (scl_rise)
		begin
			if (state_reg.st == ST_RACK)
			begin
				state_next.ack_ok = ~state_reg.sda.s2;
			end
			// acknowledge bits are not shifted in, so the direction bit
			// of the address byte still sits at the bottom of the shifter
			else if (state_reg.st != ST_ADDR_ACK && state_reg.st != ST_WPTR_ACK
				&& state_reg.st != ST_WDATA_ACK)
			begin
				state_next.sh = {state_reg.sh[6:0], state_reg.sda.s2};
				state_next.cnt = 4'(state_reg.cnt + 4'h1);
			end
		end
		// falling edge: move on and set up the next data bit
		else if (scl_fall)
		begin
			unique case (state_reg.st)
				ST_IDLE:
				begin
					state_next.sda_oe = 1'b0;
				end
				ST_ADDR:
				begin
					if (state_reg.cnt == 4'h8)
					begin
						// other targets' addresses are ignored silently
						if (state_reg.sh[7:1] == `CCR_I2C_ADDR)
						begin
							state_next.st = ST_ADDR_ACK;
							state_next.sda_oe = 1'b1;
						end
						else
						begin
							state_next.st = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					state_next.cnt = 4'h0;
					if (state_reg.sh[0])
					begin
						state_next.st = ST_RDATA;
						state_next.tx = rd_byte;
						state_next.sda_oe = ~rd_byte[7];
					end
					else
					begin
						state_next.st = ST_WPTR;
						state_next.sda_oe = 1'b0;
					end
				end
				ST_WPTR:
				begin
					if (state_reg.cnt == 4'h8)
					begin
						state_next.ptr = state_reg.sh;
						state_next.st = ST_WPTR_ACK;
						state_next.sda_oe = 1'b1;
					end
				end
				ST_WPTR_ACK, ST_WDATA_ACK:
				begin
					state_next.cnt = 4'h0;
					state_next.st = ST_WDATA;
					state_next.sda_oe = 1'b0;
				end
				ST_WDATA:
				begin
					if (state_reg.cnt == 4'h8)
					begin
						// pointer steps on so bursts fill neighbours
						wr_en = 1'b1;
						state_next.ptr = 8'(state_reg.ptr + 8'h01);
						state_next.st = ST_WDATA_ACK;
						state_next.sda_oe = 1'b1;
					end
				end
				ST_RDATA:
				begin
					if (state_reg.cnt == 4'h8)
					begin
						state_next.sda_oe = 1'b0;
						state_next.ptr = 8'(state_reg.ptr + 8'h01);
						state_next.st = ST_RACK;
					end
					else
					begin
						state_next.tx = {state_reg.tx[6:0], 1'b0};
						state_next.sda_oe = ~state_reg.tx[6];
					end
				end
				ST_RACK:
				begin
					// a not-acknowledge ends the read burst
					if (state_reg.ack_ok)
					begin
						state_next.cnt = 4'h0;
						state_next.st = ST_RDATA;
						state_next.tx = rd_byte;
						state_next.sda_oe = ~rd_byte[7];
					end
					else
					begin
						state_next.st = ST_IDLE;
					end
				end
				default:
				begin
					state_next.st = ST_IDLE;
					state_next.sda_oe = 1'b0;
				end
			endcase
		end

		// plug-in clears the mode; a write in the same cycle wins
		if (plug_rise)
		begin
			state_next.ctl_b.high_impedance_mode = 1'b0;
		end

		// register writes
		if (wr_en)
		begin
			case (state_reg.ptr)
				`CCR_ADDR_CTL_A:
				begin
					state_next.ctl_a = ccr_ctl_a_s'(state_reg.sh);
				end
				`CCR_ADDR_CTL_B:
				begin
					state_next.ctl_b = ccr_ctl_b_s'(state_reg.sh);
					state_next.ctl_b.watchdog_kick = 1'b0;
					state_next.kick = state_reg.sh[`CCR_KICK_BIT];
				end
				`CCR_ADDR_CTL_C:
				begin
					state_next.soft_rst = state_reg.sh[`CCR_REGRST_BIT];
				end
				default:
				begin
					state_next.soft_rst = state_reg.soft_rst;
				end
			endcase
		end

		// expiry reloads only the watchdog-reset fields
		if (wd_fire)
		begin
			state_next.ctl_a.termination_enable = 1'b1;
			state_next.ctl_b.forced_battery_pulldown = 1'b0;
			state_next.ctl_b.charge_enable = 1'b1;
			state_next.ctl_b.high_impedance_mode = 1'b0;
			state_next.ctl_b.mid_node_pulldown = 1'b0;
		end

		// register reset takes one cycle, then the bit reads zero
		if (state_reg.soft_rst)
		begin
			state_next.ctl_a = ccr_ctl_a_s'(`CCR_RST_CTL_A);
			state_next.ctl_b = ccr_ctl_b_s'(`CCR_RST_CTL_B);
			state_next.soft_rst = 1'b0;
		end
	end

	// state register, with the documented power-on values
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.st <= ST_IDLE;
			state_reg.ctl_a <= ccr_ctl_a_s'(`CCR_RST_CTL_A);
			state_reg.ctl_b <= ccr_ctl_b_s'(`CCR_RST_CTL_B);
			state_reg.scl <= 3'b111; // idle bus is high
			state_reg.sda <= 3'b111;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// open-drain data: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = state_reg.sda_oe;

	// control outputs straight from the register fields, discharge and expiry from their own flops
	assign input_switch_full_on = state_reg.ctl_a.input_switch_full_on;
	assign battery_switch_full_on = state_reg.ctl_a.battery_switch_full_on;
	assign trickle_current_sel = state_reg.ctl_a.trickle_current_sel;
	assign topoff_duration = state_reg.ctl_a.topoff_duration;
	assign termination_enable = state_reg.ctl_a.termination_enable;
	assign input_limit_tracking = state_reg.ctl_a.input_limit_tracking;
	assign recharge_offset = state_reg.ctl_a.recharge_offset;
	assign battery_discharge_on = state_reg.dsch_on;
	assign forced_battery_pulldown = state_reg.ctl_b.forced_battery_pulldown;
	assign charge_enable = state_reg.ctl_b.charge_enable;
	assign high_impedance_mode = state_reg.ctl_b.high_impedance_mode;
	assign mid_node_pulldown = state_reg.ctl_b.mid_node_pulldown;
	assign watchdog_period = state_reg.ctl_b.watchdog_period;
	assign watchdog_expired = wd_fire;

endmodule // ccr_charger_ctrl
`default_nettype wire

// ==== dv/ccr_charger_ctrl_sva.sv ====
// port assertions for the charger control register bank
`timescale 1ns/1ps
`default_nettype none

module ccr_charger_ctrl_sva (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic adapter_present,
	input wire logic battery_ovp_fault,
	input wire logic input_switch_full_on,
	input wire logic trickle_current_sel,
	input wire logic [1:0] topoff_duration,
	input wire logic termination_enable,
	input wire logic battery_discharge_on,
	input wire logic forced_battery_pulldown,
	input wire logic charge_enable,
	input wire logic high_impedance_mode,
	input wire logic mid_node_pulldown,
	input wire logic [1:0] watchdog_period,
	input wire logic watchdog_expired
);
	// packed views of the first and second register settings
	wire logic [4:0] a_now = {input_switch_full_on, trickle_current_sel, topoff_duration,
		termination_enable};
	wire logic [5:0] b_now = {forced_battery_pulldown, charge_enable, high_impedance_mode,
		mid_node_pulldown, watchdog_period};

	// one domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	chk_reset_vals: assert property ($rose(rstn) |->
		a_now == 5'h09 && b_now == 6'h11) else $error("defaults wrong after reset");
	chk_wd_pulse: assert property (watchdog_expired |=> !watchdog_expired)
		else $error("expiry pulse longer than one cycle");
	chk_wd_off: assert property ((watchdog_period == 2'b00) [*3] |-> !watchdog_expired)
		else $error("expiry while watchdog disabled");
	chk_wd_reload: assert property (watchdog_expired |->
		##[0:2] (b_now[5:2] == 4'h4 && termination_enable)) else $error("expiry reload wrong");
	chk_wd_keep: assert property (watchdog_expired |=>
		$stable(watchdog_period) && $stable(a_now[4:1])) else $error("expiry touched other fields");
	chk_plug_clear: assert property ($rose(adapter_present) |->
		##[2:6] !high_impedance_mode) else $error("plug-in left high impedance set");
	chk_disch_off: assert property ((!battery_ovp_fault) [*4] |-> !battery_discharge_on)
		else $error("discharge without fault");
	chk_cfg_hold: assert property (scl_in [*8] |-> $stable(a_now[4:1]))
		else $error("setting changed with bus idle");

	// main scenarios reached
	cover property (watchdog_expired);
	cover property ($rose(battery_discharge_on));
	cover property ($rose(adapter_present) ##[1:6] $fell(high_impedance_mode));
endmodule // ccr_charger_ctrl_sva

bind ccr_charger_ctrl ccr_charger_ctrl_sva ccr_charger_ctrl_sva_i (
	.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .adapter_present(adapter_present),
	.battery_ovp_fault(battery_ovp_fault), .input_switch_full_on(input_switch_full_on),
	.trickle_current_sel(trickle_current_sel), .topoff_duration(topoff_duration),
	.termination_enable(termination_enable), .battery_discharge_on(battery_discharge_on),
	.forced_battery_pulldown(forced_battery_pulldown), .charge_enable(charge_enable),
	.high_impedance_mode(high_impedance_mode), .mid_node_pulldown(mid_node_pulldown),
	.watchdog_period(watchdog_period), .watchdog_expired(watchdog_expired)
);
`default_nettype wire

// ==== dv/ccr_host.sv ====
// host processor model on the two-wire serial bus
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"

module ccr_host (
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	// bus idles released; the clock stands high outside frames
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// wait a number of clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// data moves mid-low so it never changes near a clock edge
	task automatic bit_io(input logic b, output logic r);
		tick(4);
		sda <= b;
		tick(4);
		scl <= 1'b1;
		tick(8);
		r = sda_line;
		scl <= 1'b0;
	endtask

	// start or repeated start
	task automatic start();
		tick(4);
		sda <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(8);
		sda <= 1'b0;
		tick(8);
		scl <= 1'b0;
	endtask

	// stop leaves both lines released
	task automatic stop();
		tick(4);
		sda <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(8);
		sda <= 1'b1;
		tick(8);
	endtask

	// eight bits msb first, then the acknowledge bit
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, r);
		ack = !r;
	endtask

	// pointer then one data byte
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic ack;
		start();
		byte_io({`CCR_I2C_ADDR, 1'b0}, 1'b1, q, ack);
		byte_io(a, 1'b1, q, ack);
		byte_io(d, 1'b1, q, ack);
		stop();
	endtask

	// pointer, repeated start, one byte ended by a refusal
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a1;
		logic a2;
		logic a3;
		start();
		byte_io({`CCR_I2C_ADDR, 1'b0}, 1'b1, q, a1);
		byte_io(a, 1'b1, q, a2);
		start();
		byte_io({`CCR_I2C_ADDR, 1'b1}, 1'b1, q, a3);
		byte_io(8'hff, 1'b1, d, ok);
		ok = a1 & a2 & a3;
		stop();
	endtask
endmodule // ccr_host
`default_nettype wire

// ==== dv/ccr_charger_ctrl_tb.sv ====
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
`default_nettype none

module ccr_charger_ctrl_tb;
	localparam logic [32:0] WD_BASE = 33'h0fa0; // shortened watchdog base, 4000 cycles
	logic ref_clk;
	logic rstn;
	logic ovp;
	logic plug;
	logic scl;
	logic host_sda;
	logic sda_oe;
	wire logic sda_drv; // level the device puts on the data line while enabled
	wire logic sda_line = host_sda & (sda_oe ? sda_drv : 1'b1); // pulled-up wire
	wire logic [7:0] a_pins; // first register settings
	wire logic [7:0] b_pins; // discharge, second settings, expiry at bit 2
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	ccr_charger_ctrl #(.WD_BASE_CYCLES(WD_BASE)) ccr_charger_ctrl_i (
		.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
		.sda_oe(sda_oe), .battery_ovp_fault(ovp), .adapter_present(plug),
		.input_switch_full_on(a_pins[7]), .battery_switch_full_on(a_pins[6]),
		.trickle_current_sel(a_pins[5]), .topoff_duration(a_pins[4:3]),
		.termination_enable(a_pins[2]), .input_limit_tracking(a_pins[1]),
		.recharge_offset(a_pins[0]), .battery_discharge_on(b_pins[7]),
		.forced_battery_pulldown(b_pins[6]), .charge_enable(b_pins[5]),
		.high_impedance_mode(b_pins[4]), .mid_node_pulldown(b_pins[3]),
		.watchdog_period(b_pins[1:0]), .watchdog_expired(b_pins[2])
	);

	ccr_host ccr_host_i (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));

	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		ccr_host_i.wr(a, d);
	endtask

	// read back, the acknowledge too
	task automatic r(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		logic ok;
		ccr_host_i.rd(a, q, ok);
		chk(q, exp);
		chk({7'h0, ok}, 8'h01);
	endtask

	task automatic t_reset();
		chk(a_pins, 8'h26);
		chk(b_pins & 8'h7b, 8'h21);
		r(8'h15, 8'h26);
		r(8'h16, 8'ha1);
		w(8'h16, 8'h20);
	endtask

	// every top-off code, every other bit both ways
	task automatic t_ctl_a();
		logic [1:0] c;
		logic [7:0] v;
		for (int k = 0; k < 4; k++)
		begin
			c = 2'(k);
			v = {c[0], c[1], ~c[0], c, ~c[1], c[0], ~c[0]};
			w(8'h15, v);
			r(8'h15, v);
			chk(a_pins, v);
		end
	endtask

	task automatic t_ctl_b();
		w(8'h16, 8'h58);
		r(8'h16, 8'h58);
		chk(b_pins & 8'h7b, 8'h58);
		w(8'h16, 8'h5c);
		r(8'h16, 8'h58);
		ovp <= 1'b1;
		ccr_host_i.tick(8);
		chk(b_pins & 8'h80, 8'h00);
		w(8'h16, 8'hd8);
		ccr_host_i.tick(4);
		chk(b_pins & 8'h80, 8'h80);
		ovp <= 1'b0;
		plug <= 1'b1;
		ccr_host_i.tick(8);
		chk(b_pins & 8'h90, 8'h00);
		plug <= 1'b0;
		r(8'h16, 8'hc8);
		w(8'h17, 8'h7f);
		r(8'h17, 8'h00);
		r(8'h20, 8'h00);
	endtask

	// expiry time per code after a late kick, and what it reloads
	task automatic t_wdog();
		int n;
		int p;
		for (int c = 0; c < 4; c++)
		begin
			p = (c == 0) ? 5000 : (4000 << (c - 1));
			w(8'h15, 8'hd9);
			w(8'h16, 8'h58 | 8'(c));
			ccr_host_i.tick(1000);
			w(8'h16, 8'h5c | 8'(c));
			n = 0;
			while (b_pins[2] !== 1'b1 && n < p + 200)
			begin
				// the one-cycle pulse is read mid-cycle, away from its launching edge
				@(negedge ref_clk);
				n++;
			end
			chk(8'((c == 0) ? (n == p + 200) : (n > p - 80 && n < p - 10)), 8'h01);
			r(8'h16, (c == 0) ? 8'h58 : (8'h20 | 8'(c)));
			r(8'h15, (c == 0) ? 8'hd9 : 8'hdd);
		end
		w(8'h16, 8'h20);
	endtask

	task automatic t_soft();
		w(8'h17, 8'h80);
		r(8'h17, 8'h00);
		r(8'h15, 8'h26);
		r(8'h16, 8'ha1);
	endtask

	// cycle ceiling cuts a hang short
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			err_count++;
			$display("ERROR %0t timeout", $time);
			final_report();
		end
	end

	// reset, then the scenarios in order
	initial
	begin
		rstn = 1'b0;
		ovp = 1'b0;
		plug = 1'b0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge ref_clk);
		t_reset();
		t_ctl_a();
		t_ctl_b();
		t_wdog();
		t_soft();
		final_report();
	end
endmodule // ccr_charger_ctrl_tb
`default_nettype wire
